// File: hdl/fnom_pkg.sv
// Shared constants and carrier types of the frame number offset mapper
package fnom_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FRAME_NS      = 10_000_000;
  localparam int unsigned FRAME_CYC     = FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned CHIP_RATE_HZ  = 3_840_000;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned STEP_CHIPS    = 256;
  localparam int unsigned STEP_CYC      =
    int'((64'(STEP_CHIPS) * 64'(CLK_HZ)) / 64'(CHIP_RATE_HZ));
  localparam int unsigned TICK_W        = 20;
  // ---------------------------------------------------------------
  // Counter and offset ranges
  // ---------------------------------------------------------------
  localparam logic [11:0] FN_MAX        = 12'h0_FFF;
  localparam logic [3:0]  DELAY_MAX     = 4'h9;
  localparam logic [15:0] CHIP_MAX      = 16'h9_5FF;
  localparam logic [15:0] CHIPS_FRAME   = 16'h9_600;
  localparam logic [7:0]  STEPS_FRAME   = 8'h96;
  localparam logic [7:0]  HALF_STEP     = 8'h80;
  // ---------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_CELL_DELAY = 8'h04;
  localparam logic [7:0] REG_FRAME_OFS  = 8'h08;
  localparam logic [7:0] REG_CHIP_OFS   = 8'h0C;
  localparam logic [7:0] REG_NODE_FN    = 8'h10;
  localparam logic [7:0] REG_CELL_FN    = 8'h14;
  localparam logic [7:0] REG_DL_TIMING  = 8'h18;
  localparam logic [7:0] REG_STATUS     = 8'h1C;
  localparam int unsigned CTRL_RUN      = 0;
  localparam int unsigned CTRL_TDD      = 1;
  localparam int unsigned CTRL_SYNC     = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h1;
  localparam int unsigned DL_SLOT_LSB   = 16;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  typedef struct packed {
    logic              pch;
    logic [11:0]       frame;
    logic [DATA_W-1:0] data;
  } fnom_tbs_t;
  typedef enum logic {TX_IDLE, TX_WAIT} fnom_tx_state_t;
endpackage : fnom_pkg

// File: hdl/fnom_cfn_map.sv
// Connection frame to cell frame mapping, one direction
`timescale 1ns/10ps
module fnom_cfn_map #(
  parameter bit TO_AIR = 1'b1
) (
  input  wire logic [11:0] frame_in,
  input  wire logic [7:0]  frame_ofs,
  input  wire logic        pch,
  output logic      [11:0] frame_out
);
  logic [7:0] low;

  always_comb begin
    if (TO_AIR) begin
      low = frame_in[7:0] + frame_ofs;
    end else begin
      low = frame_in[7:0] - frame_ofs;
    end
    if (pch) begin
      frame_out = frame_in;
    end else begin
      frame_out = {4'h0, low};
    end
  end
endmodule : fnom_cfn_map

// File: hdl/fnom_round.sv
// Frame plus chip offset rounding to whole 256-chip steps
`timescale 1ns/10ps
module fnom_round (
  input  wire logic [7:0]  frame_ofs,
  input  wire logic [15:0] chip_ofs,
  output logic      [15:0] steps,
  output logic      [7:0]  slot
);
  logic [23:0] sum;
  logic [15:0] base;
  logic [15:0] up;

  always_comb begin
    sum  = 24'(frame_ofs) * 24'(fnom_pkg::CHIPS_FRAME) + 24'(chip_ofs);
    base = sum[23:8];
    up   = base + 16'h0_001;
    if (sum[7:0] == 8'h00) begin
      steps = base;
    end else if (sum[7:0] < fnom_pkg::HALF_STEP) begin
      steps = base;
    end else if (up == fnom_pkg::CHIPS_FRAME) begin
      steps = 16'h0_000;
    end else begin
      steps = up;
    end
    slot = 8'(steps % 16'(fnom_pkg::STEPS_FRAME));
  end
endmodule : fnom_round

// File: hdl/fnom_top.sv
// Frame counters, frame number mapping and downlink offset rounding
`timescale 1ns/10ps
module fnom_top #(
  parameter int unsigned FRAME_CYC = fnom_pkg::FRAME_CYC,
  parameter int unsigned STEP_CYC  = fnom_pkg::STEP_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic                     wb_ack_o,
  output logic      [31:0]         wb_dat_o,
  input  wire logic                tx_in_valid,
  output logic                     tx_in_ready,
  input  wire fnom_pkg::fnom_tbs_t tx_in,
  output logic                     tx_out_valid,
  output fnom_pkg::fnom_tbs_t      tx_out,
  input  wire logic                rx_in_valid,
  input  wire fnom_pkg::fnom_tbs_t rx_in,
  output logic                     rx_out_valid,
  output fnom_pkg::fnom_tbs_t      rx_out,
  output logic                     frame_tick,
  output logic      [11:0]         node_frame_counter,
  output logic      [11:0]         cell_frame_number,
  output logic      [15:0]         dl_offset_steps
);
  logic [2:0]                      ctrl;
  logic [3:0]                      cell_delay;
  logic [7:0]                      frame_ofs;
  logic [15:0]                     chip_ofs;
  logic [7:0]                      dl_slot;
  logic [fnom_pkg::TICK_W-1:0]     tick_cnt;
  logic [fnom_pkg::TICK_W-1:0]     cell_pos;
  logic                            node_tick;
  logic                            cell_tick;
  logic                            tdd_sync;
  logic [11:0]                     node_next;
  logic [11:0]                     next_cell;
  logic                            wb_req;
  logic [31:0]                     rd_word;
  fnom_pkg::fnom_tx_state_t        tx_state;
  fnom_pkg::fnom_tbs_t             tx_hold;
  logic [11:0]                     tx_target;
  logic [11:0]                     rx_cfn;
  logic [15:0]                     rnd_steps;
  logic [7:0]                      rnd_slot;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : merge

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl       <= fnom_pkg::CTRL_RESET;
      cell_delay <= 4'h0;
      frame_ofs  <= 8'h00;
      chip_ofs   <= 16'h0_000;
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == fnom_pkg::REG_CTRL) begin
        ctrl <= 3'(merge({29'h0, ctrl}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == fnom_pkg::REG_CELL_DELAY) begin
        if (merge({28'h0, cell_delay}, wb_dat_i, wb_sel_i)
            <= 32'(fnom_pkg::DELAY_MAX)) begin
          cell_delay <= 4'(merge({28'h0, cell_delay}, wb_dat_i,
                                 wb_sel_i));
        end else begin
          cell_delay <= fnom_pkg::DELAY_MAX;
        end
      end else if (wb_adr_i == fnom_pkg::REG_FRAME_OFS) begin
        frame_ofs <= 8'(merge({24'h0, frame_ofs}, wb_dat_i,
                              wb_sel_i));
      end else if (wb_adr_i == fnom_pkg::REG_CHIP_OFS) begin
        if (merge({16'h0, chip_ofs}, wb_dat_i, wb_sel_i)
            <= 32'(fnom_pkg::CHIP_MAX)) begin
          chip_ofs <= 16'(merge({16'h0, chip_ofs}, wb_dat_i,
                                wb_sel_i));
        end else begin
          chip_ofs <= fnom_pkg::CHIP_MAX;
        end
      end
    end
  end

  always_comb begin
    if (wb_adr_i == fnom_pkg::REG_CTRL) begin
      rd_word = {29'h0, ctrl};
    end else if (wb_adr_i == fnom_pkg::REG_CELL_DELAY) begin
      rd_word = {28'h0, cell_delay};
    end else if (wb_adr_i == fnom_pkg::REG_FRAME_OFS) begin
      rd_word = {24'h0, frame_ofs};
    end else if (wb_adr_i == fnom_pkg::REG_CHIP_OFS) begin
      rd_word = {16'h0, chip_ofs};
    end else if (wb_adr_i == fnom_pkg::REG_NODE_FN) begin
      rd_word = {20'h0, node_frame_counter};
    end else if (wb_adr_i == fnom_pkg::REG_CELL_FN) begin
      rd_word = {20'h0, cell_frame_number};
    end else if (wb_adr_i == fnom_pkg::REG_DL_TIMING) begin
      rd_word = {8'h0, dl_slot, dl_offset_steps};
    end else if (wb_adr_i == fnom_pkg::REG_STATUS) begin
      rd_word = {31'h0, tx_state == fnom_pkg::TX_WAIT};
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Frame tick divider and counters
  // ---------------------------------------------------------------
  assign tdd_sync  = ctrl[fnom_pkg::CTRL_TDD] && ctrl[fnom_pkg::CTRL_SYNC];
  assign node_tick = ctrl[fnom_pkg::CTRL_RUN] &&
                     (tick_cnt == fnom_pkg::TICK_W'(FRAME_CYC - 1));
  assign cell_pos  = (cell_delay == 4'h0 || tdd_sync) ?
                     fnom_pkg::TICK_W'(FRAME_CYC - 1) :
                     fnom_pkg::TICK_W'(32'(cell_delay) * STEP_CYC - 1);
  assign cell_tick = ctrl[fnom_pkg::CTRL_RUN] && (tick_cnt == cell_pos);
  assign node_next = (node_frame_counter == fnom_pkg::FN_MAX) ?
                     12'h000 : node_frame_counter + 12'h001;
  assign frame_tick = node_tick;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tick_cnt <= '0;
    end else if (node_tick) begin
      tick_cnt <= '0;
    end else if (ctrl[fnom_pkg::CTRL_RUN]) begin
      tick_cnt <= tick_cnt + fnom_pkg::TICK_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      node_frame_counter <= 12'h000;
    end else if (node_tick) begin
      node_frame_counter <= node_next;
    end
  end

  always_comb begin
    if (tdd_sync) begin
      next_cell = {cell_frame_number[11:8] +
                   {3'h0, node_next[7:0] == 8'h00},
                   node_next[7:0]};
    end else if (cell_pos == fnom_pkg::TICK_W'(FRAME_CYC - 1)) begin
      next_cell = node_next;
    end else begin
      next_cell = node_frame_counter;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cell_frame_number <= 12'h000;
    end else if (cell_tick) begin
      cell_frame_number <= next_cell;
    end
  end

  // ---------------------------------------------------------------
  // Transmit mapping
  // ---------------------------------------------------------------
  fnom_cfn_map #(.TO_AIR(1'b1)) u_tx_map (
    .frame_in  (tx_hold.frame),
    .frame_ofs (frame_ofs),
    .pch       (tx_hold.pch),
    .frame_out (tx_target)
  );

  assign tx_in_ready = (tx_state == fnom_pkg::TX_IDLE);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_state     <= fnom_pkg::TX_IDLE;
      tx_hold      <= '0;
      tx_out_valid <= 1'b0;
      tx_out       <= '0;
    end else begin
      tx_out_valid <= 1'b0;
      case (tx_state)
        fnom_pkg::TX_IDLE: begin
          if (tx_in_valid) begin
            tx_hold  <= tx_in;
            tx_state <= fnom_pkg::TX_WAIT;
          end
        end
        fnom_pkg::TX_WAIT: begin
          if (cell_tick &&
              (tx_hold.pch ? next_cell == tx_target
                           : next_cell[7:0] == tx_target[7:0])) begin
            tx_out_valid <= 1'b1;
            tx_out       <= '{pch: tx_hold.pch, frame: next_cell,
                              data: tx_hold.data};
            tx_state     <= fnom_pkg::TX_IDLE;
          end
        end
        default: tx_state <= fnom_pkg::TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive mapping
  // ---------------------------------------------------------------
  fnom_cfn_map #(.TO_AIR(1'b0)) u_rx_map (
    .frame_in  (rx_in.frame),
    .frame_ofs (frame_ofs),
    .pch       (rx_in.pch),
    .frame_out (rx_cfn)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_out_valid <= 1'b0;
      rx_out       <= '0;
    end else begin
      rx_out_valid <= rx_in_valid;
      if (rx_in_valid) begin
        rx_out <= '{pch: rx_in.pch, frame: rx_cfn,
                    data: rx_in.data};
      end
    end
  end

  // ---------------------------------------------------------------
  // Downlink timing rounding
  // ---------------------------------------------------------------
  fnom_round u_round (
    .frame_ofs (frame_ofs),
    .chip_ofs  (chip_ofs),
    .steps     (rnd_steps),
    .slot      (rnd_slot)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dl_offset_steps <= 16'h0_000;
      dl_slot         <= 8'h00;
    end else begin
      dl_offset_steps <= rnd_steps;
      dl_slot         <= rnd_slot;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [23:0] chk_sum;
  logic [7:0]  chk_rem;
  assign chk_sum = 24'(frame_ofs) * 24'(fnom_pkg::CHIPS_FRAME) +
                   24'(chip_ofs);
  assign chk_rem = chk_sum[7:0];

  property p_node_wrap;
    @(posedge mclk) disable iff (!rst_b)
    node_tick && node_frame_counter == 12'hFFF |=>
      node_frame_counter == 12'h000;
  endproperty
  a_node_wrap: assert property (p_node_wrap)
    else $error("node counter did not wrap");

  property p_node_step;
    @(posedge mclk) disable iff (!rst_b)
    !node_tick |=> node_frame_counter == $past(node_frame_counter);
  endproperty
  a_node_step: assert property (p_node_step)
    else $error("node counter moved without tick");

  property p_cell_zero;
    @(posedge mclk) disable iff (!rst_b)
    node_tick && cell_delay == 4'h0 && !tdd_sync |=>
      cell_frame_number == node_frame_counter;
  endproperty
  a_cell_zero: assert property (p_cell_zero)
    else $error("cell frame differs with zero delay");

  property p_delay_max;
    @(posedge mclk) disable iff (!rst_b) cell_delay <= 4'h9;
  endproperty
  a_delay_max: assert property (p_delay_max)
    else $error("cell delay above nine steps");

  property p_tdd_lock;
    @(posedge mclk) disable iff (!rst_b)
    tdd_sync && node_tick |=>
      cell_frame_number[7:0] == node_frame_counter[7:0];
  endproperty
  a_tdd_lock: assert property (p_tdd_lock)
    else $error("cell low byte not locked");

  property p_tx_frame;
    @(posedge mclk) disable iff (!rst_b)
    tx_out_valid && !tx_out.pch |->
      tx_out.frame[7:0] == cell_frame_number[7:0] &&
      tx_out.frame[7:0] == 8'(tx_hold.frame[7:0] + $past(frame_ofs));
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("block sent in wrong frame");

  property p_rx_map;
    @(posedge mclk) disable iff (!rst_b)
    rx_in_valid && !rx_in.pch |=> rx_out_valid &&
      rx_out.frame[7:0] == 8'($past(rx_in.frame[7:0]) - $past(frame_ofs));
  endproperty
  a_rx_map: assert property (p_rx_map)
    else $error("receive cfn mapped wrongly");

  property p_chip_max;
    @(posedge mclk) disable iff (!rst_b) chip_ofs <= 16'h9_5FF;
  endproperty
  a_chip_max: assert property (p_chip_max)
    else $error("chip offset out of range");

  property p_round;
    @(posedge mclk) disable iff (!rst_b)
    $stable(frame_ofs) && $stable(chip_ofs) && chk_rem < 8'h80 |->
      dl_offset_steps == chk_sum[23:8];
  endproperty
  a_round: assert property (p_round)
    else $error("rounding down wrong");

  property p_dl_max;
    @(posedge mclk) disable iff (!rst_b) dl_slot <= 8'h95;
  endproperty
  a_dl_max: assert property (p_dl_max)
    else $error("downlink offset above maximum");

  c_node_wrap: cover property (@(posedge mclk) disable iff (!rst_b)
    node_tick && node_frame_counter == 12'hFFF);
  c_tx_sent: cover property (@(posedge mclk) disable iff (!rst_b)
    tx_out_valid);
  c_round_up: cover property (@(posedge mclk) disable iff (!rst_b)
    $stable(chip_ofs) && chk_rem >= 8'h80);
endmodule : fnom_top

// File: verification/fnom_ctrl_model.sv
// Controller model: own frame counter and offset delivery over the bus
`timescale 1ns/10ps
module fnom_ctrl_model #(
  parameter int unsigned FRAME_CYC = 20
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  output logic             wb_cyc,
  output logic             wb_stb,
  output logic             wb_we,
  output logic      [7:0]  wb_adr,
  output logic      [3:0]  wb_sel,
  output logic      [31:0] wb_dat_w,
  input  wire logic        wb_ack,
  input  wire logic [31:0] wb_dat_r
);
  logic        [11:0] controller_frame_counter;
  int unsigned        div;

  initial begin
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_sel   = 4'h0;
    wb_dat_w = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Own frame counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div                      <= 0;
      controller_frame_counter <= 12'h000;
    end else if (div == FRAME_CYC - 1) begin
      div                      <= 0;
      controller_frame_counter <= controller_frame_counter + 12'h001;
    end else begin
      div <= div + 1;
    end
  end

  // ---------------------------------------------------------------
  // Register access and offset delivery
  // ---------------------------------------------------------------
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] rdat);
    @(posedge mclk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_sel   <= 4'hF;
    wb_dat_w <= dat;
    do begin
      @(posedge mclk);
    end while (wb_ack !== 1'b1);
    rdat = wb_dat_r;
    wb_cyc   <= 1'b0;
    wb_stb   <= 1'b0;
    wb_we    <= 1'b0;
    wb_adr   <= ~adr;
    wb_dat_w <= ~dat;
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] t;
    xfer(1'b1, adr, dat, t);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
    xfer(1'b0, adr, 32'h0000_0000, dat);
  endtask : rd

  task automatic setup_link_fdd(input logic [9:0] default_link_offset_fdd);
    int unsigned chips;
    chips = default_link_offset_fdd * 512;
    wr(fnom_pkg::REG_FRAME_OFS, 32'(chips / 38400));
    wr(fnom_pkg::REG_CHIP_OFS, 32'(chips % 38400));
  endtask : setup_link_fdd

  task automatic setup_link_tdd(input logic [2:0] default_link_offset_tdd);
    wr(fnom_pkg::REG_FRAME_OFS, 32'(default_link_offset_tdd));
  endtask : setup_link_tdd
endmodule : fnom_ctrl_model

// File: verification/test_frame_number_offset_mapper.sv
// Self-checking bench of the frame number offset mapper
`timescale 1ns/10ps
module test_frame_number_offset_mapper;
  localparam int unsigned FC = 20;
  localparam int unsigned SC = 2;
  logic                mclk;
  logic                rst_b;
  logic                wb_cyc;
  logic                wb_stb;
  logic                wb_we;
  logic [7:0]          wb_adr;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_dat_w;
  logic                wb_ack;
  logic [31:0]         wb_dat_r;
  logic                tx_in_valid;
  logic                tx_in_ready;
  fnom_pkg::fnom_tbs_t tx_in;
  logic                tx_out_valid;
  fnom_pkg::fnom_tbs_t tx_out;
  logic                rx_in_valid;
  fnom_pkg::fnom_tbs_t rx_in;
  logic                rx_out_valid;
  fnom_pkg::fnom_tbs_t rx_out;
  logic                frame_tick;
  logic [11:0]         node_frame_counter;
  logic [11:0]         cell_frame_number;
  logic [15:0]         dl_offset_steps;
  int                  failures = 0;
  int                  total_checks = 0;
  int                  cycles = 0;

  fnom_top #(.FRAME_CYC(FC), .STEP_CYC(SC)) dut (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat_r),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in(tx_in),
    .tx_out_valid(tx_out_valid), .tx_out(tx_out),
    .rx_in_valid(rx_in_valid), .rx_in(rx_in),
    .rx_out_valid(rx_out_valid), .rx_out(rx_out),
    .frame_tick(frame_tick), .node_frame_counter(node_frame_counter),
    .cell_frame_number(cell_frame_number),
    .dl_offset_steps(dl_offset_steps));

  fnom_ctrl_model #(.FRAME_CYC(FC)) u_ctrl (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_tick;
    do @(negedge mclk); while (frame_tick !== 1'b1);
  endtask : wait_tick

  task automatic send(input logic pch, input logic [11:0] fn,
                      input logic [31:0] d);
    @(posedge mclk);
    tx_in_valid <= 1'b1;
    tx_in       <= '{pch, fn, d};
    do @(posedge mclk); while (tx_in_ready !== 1'b1);
    tx_in_valid <= 1'b0;
    @(negedge mclk);
    check("tx_in_ready", 32'h0000_0000, tx_in_ready);
    while (tx_out_valid !== 1'b1) @(negedge mclk);
  endtask : send

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      failures++;
      $display("BAD run time expected end seen timeout");
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] v;
    @(negedge mclk);
    check("node", 32'h0000_0000, node_frame_counter);
    check("tx_in_ready", 32'h0000_0001, tx_in_ready);
    u_ctrl.rd(fnom_pkg::REG_NODE_FN, v);
    check("node reg", 32'h0000_0000, v);
    u_ctrl.rd(fnom_pkg::REG_CTRL, v);
    check("ctrl", 32'h0000_0001, v);
    u_ctrl.wr(8'h20, 32'hFFFF_FFFF);
    u_ctrl.rd(8'h20, v);
    check("unmapped", 32'h0000_0000, v);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_count;
    logic [11:0] n;
    int          k;
    wait_tick();
    n = node_frame_counter;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (frame_tick !== 1'b1);
    check("frame period", FC, k);
    check("node step", n + 12'h001, node_frame_counter);
    u_ctrl.wr(fnom_pkg::REG_CTRL, 32'h0000_0000);
    n = node_frame_counter;
    repeat (FC) @(negedge mclk);
    check("halt", n, node_frame_counter);
    u_ctrl.wr(fnom_pkg::REG_CTRL, 32'h0000_0001);
    $display("test count finished");
  endtask : t_count

  task automatic t_delay;
    int unsigned dl [3] = '{0, 9, 3};
    int          k;
    logic [31:0] v;
    foreach (dl[i]) begin
      u_ctrl.wr(fnom_pkg::REG_CELL_DELAY, 32'(dl[i]));
      wait_tick();
      wait_tick();
      @(negedge mclk);
      k = 0;
      while (cell_frame_number !== node_frame_counter && k < 40) begin
        @(negedge mclk);
        k++;
      end
      check("cell delay cycles", dl[i] * SC, k);
    end
    u_ctrl.wr(fnom_pkg::REG_CELL_DELAY, 32'h0000_000C);
    u_ctrl.rd(fnom_pkg::REG_CELL_DELAY, v);
    check("cell delay clamp", 32'h0000_0009, v);
    u_ctrl.wr(fnom_pkg::REG_CELL_DELAY, 32'h0000_0000);
    $display("test delay finished");
  endtask : t_delay

  task automatic t_tdd;
    u_ctrl.wr(fnom_pkg::REG_CTRL, 32'h0000_0007);
    u_ctrl.wr(fnom_pkg::REG_CELL_DELAY, 32'h0000_0005);
    repeat (3) begin
      wait_tick();
      @(negedge mclk);
      check("low byte", node_frame_counter[7:0], cell_frame_number[7:0]);
    end
    u_ctrl.wr(fnom_pkg::REG_CTRL, 32'h0000_0001);
    u_ctrl.wr(fnom_pkg::REG_CELL_DELAY, 32'h0000_0000);
    $display("test tdd finished");
  endtask : t_tdd

  task automatic t_tx;
    logic [7:0]  of [2] = '{8'hF0, 8'h00};
    logic [7:0]  cn [2] = '{8'h25, 8'hFF};
    logic [11:0] f;
    foreach (of[i]) begin
      u_ctrl.wr(fnom_pkg::REG_FRAME_OFS, 32'(of[i]));
      send(1'b0, {4'h0, cn[i]}, 32'hC0DE_0000 + i);
      check("tx frame", 8'(of[i] + cn[i]), tx_out.frame[7:0]);
      check("tx cell", 8'(of[i] + cn[i]), cell_frame_number[7:0]);
      check("tx data", 32'hC0DE_0000 + i, tx_out.data);
    end
    @(negedge mclk);
    f = cell_frame_number + 12'h003;
    send(1'b1, f, 32'hC0DE_00AA);
    check("pch frame", f, tx_out.frame);
    check("pch cell", f, cell_frame_number);
    check("pch flag", 32'h0000_0001, tx_out.pch);
    $display("test tx finished");
  endtask : t_tx

  task automatic t_rx;
    u_ctrl.wr(fnom_pkg::REG_FRAME_OFS, 32'h0000_00F0);
    @(posedge mclk);
    rx_in_valid <= 1'b1;
    rx_in       <= '{1'b0, 12'h010, 32'hBEEF_0001};
    @(posedge mclk);
    rx_in       <= '{1'b0, 12'hA05, 32'hBEEF_0002};
    @(negedge mclk);
    check("rx valid", 32'h0000_0001, rx_out_valid);
    check("rx frame", 8'h20, rx_out.frame[7:0]);
    check("rx data", 32'hBEEF_0001, rx_out.data);
    @(posedge mclk);
    rx_in_valid <= 1'b0;
    @(negedge mclk);
    check("rx frame", 8'h15, rx_out.frame[7:0]);
    check("rx data", 32'hBEEF_0002, rx_out.data);
    @(negedge mclk);
    check("rx valid", 32'h0000_0000, rx_out_valid);
    $display("test rx finished");
  endtask : t_rx

  task automatic t_round;
    int unsigned fo [6] = '{0, 0, 0, 1, 255, 2};
    int unsigned ch [6] = '{0, 127, 128, 255, 38399, 38399};
    int unsigned e;
    logic [31:0] v;
    foreach (fo[i]) begin
      u_ctrl.wr(fnom_pkg::REG_FRAME_OFS, fo[i]);
      u_ctrl.wr(fnom_pkg::REG_CHIP_OFS, ch[i]);
      e = ((fo[i] * 38400 + ch[i] + 128) / 256) % 38400;
      repeat (3) @(posedge mclk);
      check("steps", e, dl_offset_steps);
      u_ctrl.rd(fnom_pkg::REG_DL_TIMING, v);
      check("dl reg", e, v[15:0]);
      check("dl slot", e % 150, v[23:16]);
    end
    u_ctrl.setup_link_fdd(10'd599);
    repeat (3) @(posedge mclk);
    check("steps", 32'd1198, dl_offset_steps);
    u_ctrl.setup_link_tdd(3'd7);
    u_ctrl.wr(fnom_pkg::REG_CHIP_OFS, 32'h0000_FFFF);
    u_ctrl.rd(fnom_pkg::REG_CHIP_OFS, v);
    check("chip clamp", 32'h0000_95FF, v);
    check("steps", 32'h0000_04B0, dl_offset_steps);
    $display("test round finished");
  endtask : t_round

  task automatic t_wrap;
    logic [31:0] v;
    while (node_frame_counter !== 12'hFFF) @(negedge mclk);
    wait_tick();
    @(negedge mclk);
    check("wrap node", 12'h000, node_frame_counter);
    check("wrap cell", 12'h000, cell_frame_number);
    u_ctrl.rd(fnom_pkg::REG_CELL_FN, v);
    check("cell reg", 32'h0000_0000, v);
    $display("test wrap finished");
  endtask : t_wrap

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b       = 1'b0;
    tx_in_valid = 1'b0;
    tx_in       = '0;
    rx_in_valid = 1'b0;
    rx_in       = '0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_count();
    t_delay();
    t_tdd();
    t_tx();
    t_rx();
    t_round();
    t_wrap();
    end_of_test();
  end
endmodule : test_frame_number_offset_mapper
